//--- hw/config_word_and_reset_hold.sv
// How it works
// - power-up holds the core in reset for 64 ms
// - brown-out resets; delay timer can stretch it to 64 ms
// - sleep ends on external reset, watchdog wake or interrupt
// - clock source picked by a configuration field
// - programmed bit reads 0, unprogrammed bit reads 1
// - configuration word sits at address 2007h
// - 2000h-3FFFh reachable only in programming mode
// - unimplemented word bits always read 1
// - blank or bulk-erased word reads all ones
// - debugger enable is bit 13
// - debugger bit 1 disables, 0 enables the debugger
// - clock-out bit 1 gives general I/O, 0 gives instruction clock
// - write-protect 11 leaves all writable, others protect more
// - brown-out 0x off, 10 on while awake, 11 always on
module config_word_and_reset_hold
  import cfg_word_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = PWRUP_DELAY_CYC
)
(
  // clock and power-on reset
  input wire logic i_clk,
  input wire logic i_rst,
  // programming interface
  input wire logic i_prog_mode_pin,
  input wire prog_req_t i_prog_req,
  output logic [CFG_W-1:0] o_prog_rdata,
  output logic o_prog_rvalid,
  // reset, sleep and wake sources
  input wire logic i_mclr_n_pin,
  input wire logic i_brownout_pin,
  input wire logic i_sleep_req,
  input wire logic i_wdt_wake,
  input wire logic i_irq_wake,
  // core side
  output logic o_core_reset,
  output logic o_sleeping,
  output cfg_fields_t o_cfg
);

  localparam logic [CNT_W-1:0] DELAY_LOAD = CNT_W'(HOLD_CYCLES - 1);

  function automatic logic bor_on(input logic [1:0] mode, input logic asleep);
    bor_on = (mode == BOR_ON) || ((mode == BOR_AWAKE) && !asleep);
  endfunction

  function automatic logic in_cfg_space(input logic [CFG_W-1:0] addr);
    in_cfg_space = (addr >= CFG_SPACE_LO) && (addr <= CFG_SPACE_HI);
  endfunction

  function automatic cfg_fields_t decode(input cfg_word_t w, input logic asleep);
    cfg_fields_t f;
    f.debug_en = !w.debug_n;
    f.clkout_en = !w.clock_pin_output_enable_n;
    f.osc_external = !w.oscillator_select;
    f.wp_lower = (w.self_write_protect != WRT_OFF);
    f.wp_upper = (w.self_write_protect != WRT_OFF) && (w.self_write_protect != WRT_LOWER);
    f.bor_active = bor_on(w.brownout_mode, asleep);
    f.code_protect = !w.code_protect_n;
    f.mclr_en = w.master_clear_pin_enable;
    f.wdt_en = w.watchdog_enable;
    decode = f;
  endfunction

  // pin synchronisers: prog mode, mclr, brown-out
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic prog_s;
  logic mclr_n_s;
  logic brown_s;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sync1 <= 3'h2;
      sync2 <= 3'h2;
    end
    else
    begin
      sync1 <= {i_prog_mode_pin, i_mclr_n_pin, i_brownout_pin};
      sync2 <= sync1;
    end
  end

  assign prog_s = sync2[2];
  assign mclr_n_s = sync2[1];
  assign brown_s = sync2[0];

  // nonvolatile word: no reset, a blank part powers up erased
  logic [CFG_W-1:0] nv_word = CFG_ERASED;
  logic [CFG_W-1:0] next_nv;
  logic [CFG_W-1:0] next_rdata;
  logic next_rvalid;

  always_comb
  begin
    next_nv = nv_word;
    next_rdata = o_prog_rdata;
    next_rvalid = 1'h0;
    if (prog_s && in_cfg_space(i_prog_req.addr))
    begin
      if (i_prog_req.erase)
      begin
        next_nv = CFG_ERASED;
      end
      else if (i_prog_req.wr && (i_prog_req.addr == CFG_ADDR))
      begin
        // cells only move from 1 to 0 until the next erase
        next_nv = (nv_word & i_prog_req.data) | CFG_UNIMPL;
      end
      if (i_prog_req.rd)
      begin
        next_rvalid = 1'h1;
        if (i_prog_req.addr == CFG_ADDR)
        begin
          next_rdata = nv_word | CFG_UNIMPL;
        end
        else
        begin
          next_rdata = CFG_ERASED;
        end
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    nv_word <= next_nv;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_prog_rdata <= '0;
      o_prog_rvalid <= 1'h0;
    end
    else
    begin
      o_prog_rdata <= next_rdata;
      o_prog_rvalid <= next_rvalid;
    end
  end

  // reset hold and sleep sequencing
  pwr_state_t state;
  pwr_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic first_up;
  logic next_first;
  logic brown_cause;
  logic next_brown;
  cfg_word_t cfg_lat;
  cfg_word_t next_lat;
  cfg_word_t live;
  logic bor_trip;
  logic mclr_hit;
  logic hold_cause;
  logic next_core_reset;
  logic next_sleeping;
  cfg_fields_t next_cfg;

  assign live = cfg_word_t'(nv_word);
  assign bor_trip = brown_s && bor_on(cfg_lat.brownout_mode, state == ST_SLEEP);
  assign mclr_hit = cfg_lat.master_clear_pin_enable && !mclr_n_s;
  assign hold_cause = prog_s || mclr_hit || bor_trip;

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_first = first_up;
    next_brown = brown_cause;
    next_lat = cfg_lat;
    case (state)
      ST_HOLD:
      begin
        // configuration only follows the word while in ST_HOLD, not during the delay
        next_lat = live;
        if (!hold_cause)
        begin
          next_state = ST_DELAY;
          if (first_up)
          begin
            next_cnt = DELAY_LOAD;
          end
          else if (brown_cause && live.powerup_delay_enable)
          begin
            next_cnt = DELAY_LOAD;
          end
          else
          begin
            next_cnt = '0;
          end
        end
      end
      ST_DELAY:
      begin
        if (hold_cause)
        begin
          next_state = ST_HOLD;
        end
        else if (cnt == '0)
        begin
          next_state = ST_RUN;
          next_first = 1'h0;
          next_brown = 1'h0;
        end
        else
        begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_RUN:
      begin
        if (hold_cause)
        begin
          next_state = ST_HOLD;
        end
        else if (i_sleep_req)
        begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP:
      begin
        if (hold_cause)
        begin
          next_state = ST_HOLD;
        end
        else if (i_irq_wake || (i_wdt_wake && cfg_lat.watchdog_enable))
        begin
          next_state = ST_RUN;
        end
      end
      default:
      begin
        next_state = ST_HOLD;
      end
    endcase
    // a brown-out seen while clearing the flag still counts
    if (bor_trip)
    begin
      next_brown = 1'h1;
    end
    next_core_reset = (next_state == ST_HOLD) || (next_state == ST_DELAY);
    next_sleeping = (next_state == ST_SLEEP);
    next_cfg = decode(next_lat, next_sleeping);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state <= ST_HOLD;
      cnt <= '0;
      first_up <= 1'h1;
      brown_cause <= 1'h0;
      cfg_lat <= cfg_word_t'(CFG_ERASED);
      o_core_reset <= 1'h1;
      o_sleeping <= 1'h0;
      o_cfg <= decode(cfg_word_t'(CFG_ERASED), 1'h0);
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      first_up <= next_first;
      brown_cause <= next_brown;
      cfg_lat <= next_lat;
      o_core_reset <= next_core_reset;
      o_sleeping <= next_sleeping;
      o_cfg <= next_cfg;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  AST_PWRUP_LOAD: assert property (
    ($past(state) == ST_HOLD) && (state == ST_DELAY) && first_up |-> cnt == DELAY_LOAD)
    else $error("power-up delay not loaded in full");

  AST_PWRUP_HOLD: assert property (
    (state == ST_DELAY) && (cnt != '0) && !hold_cause |=> o_core_reset && (state == ST_DELAY))
    else $error("core released before delay ran out");

  AST_BOR_RESET: assert property (
    (state == ST_RUN) && bor_trip |=> (state == ST_HOLD) && o_core_reset)
    else $error("brown-out did not reset the core");

  AST_BOR_STRETCH: assert property (
    ($past(state) == ST_HOLD) && (state == ST_DELAY) && brown_cause
      && cfg_lat.powerup_delay_enable |-> cnt == DELAY_LOAD)
    else $error("brown-out reset not stretched");

  AST_WAKE: assert property (
    (state == ST_SLEEP) && i_irq_wake && !hold_cause |=> !o_sleeping && !o_core_reset)
    else $error("interrupt did not wake from sleep");

  AST_OSC: assert property (
    (state == ST_RUN) |-> o_cfg.osc_external == !cfg_lat.oscillator_select)
    else $error("clock source does not follow the latched word");

  AST_READ_WORD: assert property (
    prog_s && i_prog_req.rd && (i_prog_req.addr == CFG_ADDR)
      |=> o_prog_rvalid && (o_prog_rdata == ($past(nv_word) | CFG_UNIMPL)))
    else $error("configuration word read wrong");

  AST_PROG_ONLY: assert property (
    !prog_s |=> !o_prog_rvalid && $stable(nv_word))
    else $error("configuration space touched outside programming mode");

  AST_UNIMPL: assert property (
    o_prog_rvalid |-> (o_prog_rdata & CFG_UNIMPL) == CFG_UNIMPL)
    else $error("unimplemented bit read as zero");

  AST_ERASE: assert property (
    prog_s && i_prog_req.erase && in_cfg_space(i_prog_req.addr) |=> nv_word == CFG_ERASED)
    else $error("bulk erase did not restore ones");

  AST_DEBUG: assert property (
    (state == ST_RUN) |-> o_cfg.debug_en == !cfg_lat[CFG_W-1])
    else $error("debugger enable not from bit 13");

  AST_LATCH: assert property (
    (state != ST_HOLD) |=> $stable(cfg_lat))
    else $error("latched configuration changed outside reset");

endmodule

//--- include/cfg_word_pkg.sv
package cfg_word_pkg;

  // clock and power-up delay
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned HZ_PER_KHZ = 1_000;
  localparam int unsigned PWRUP_DELAY_MS = 64;
  localparam int unsigned PWRUP_DELAY_CYC = (CLK_HZ / HZ_PER_KHZ) * PWRUP_DELAY_MS;
  localparam int CNT_W = 21;

  // configuration word
  localparam int CFG_W = 14;
  localparam logic [CFG_W-1:0] CFG_ADDR = 14'h2007;
  localparam logic [CFG_W-1:0] CFG_SPACE_LO = 14'h2000;
  localparam logic [CFG_W-1:0] CFG_SPACE_HI = 14'h3FFF;
  localparam logic [CFG_W-1:0] CFG_ERASED = 14'h3FFF;
  localparam logic [CFG_W-1:0] CFG_UNIMPL = 14'h0086;

  // field codes
  localparam logic [1:0] WRT_OFF = 2'h3;
  localparam logic [1:0] WRT_LOWER = 2'h2;
  localparam logic [1:0] BOR_ON = 2'h3;
  localparam logic [1:0] BOR_AWAKE = 2'h2;

  // stored word, msb first
  typedef struct packed {
    logic debug_n;
    logic clock_pin_output_enable_n;
    logic [1:0] self_write_protect;
    logic [1:0] brownout_mode;
    logic unused7;
    logic code_protect_n;
    logic master_clear_pin_enable;
    logic powerup_delay_enable;
    logic watchdog_enable;
    logic [1:0] unused2;
    logic oscillator_select;
  } cfg_word_t;

  // decoded fields for the core
  typedef struct packed {
    logic debug_en;
    logic clkout_en;
    logic osc_external;
    logic wp_lower;
    logic wp_upper;
    logic bor_active;
    logic code_protect;
    logic mclr_en;
    logic wdt_en;
  } cfg_fields_t;

  // one programming request
  typedef struct packed {
    logic wr;
    logic rd;
    logic erase;
    logic [CFG_W-1:0] addr;
    logic [CFG_W-1:0] data;
  } prog_req_t;

  typedef enum logic [1:0] {
    ST_HOLD = 2'h0,
    ST_DELAY = 2'h1,
    ST_RUN = 2'h3,
    ST_SLEEP = 2'h2
  } pwr_state_t;

endpackage

//--- sim/prog_model.sv
module prog_model
  import cfg_word_pkg::*;
(
  // programming pins
  input wire logic i_clk,
  output logic o_prog_mode_pin,
  output prog_req_t o_prog_req,
  // read answer
  input wire logic [CFG_W-1:0] i_prog_rdata,
  input wire logic i_prog_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [CFG_W-1:0] last_rd;
  logic got_rd;
  initial
  begin
    o_prog_mode_pin = 1'b0;
    o_prog_req = '0;
  end
  // mode entered and synced before any request
  task automatic mode(input logic on);
    @(posedge i_clk);
    o_prog_mode_pin <= on;
    repeat (3) @(posedge i_clk);
    // step off the edge so callers see settled outputs
    #1;
  endtask
  // one-cycle strobe; idle lines show inverted last value, not a stale copy
  task automatic req(input logic w, r, e, input logic [CFG_W-1:0] a, d);
    @(posedge i_clk);
    o_prog_req <= '{wr: w, rd: r, erase: e, addr: a, data: d};
    @(posedge i_clk);
    o_prog_req <= '{wr: 1'b0, rd: 1'b0, erase: 1'b0, addr: ~a, data: ~d};
    #1;
    got_rd = i_prog_rvalid;
    last_rd = i_prog_rdata;
  endtask
endmodule

//--- sim/config_word_and_reset_hold_tb.sv
module config_word_and_reset_hold_tb
  import cfg_word_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned HOLD = 8;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_prog_mode_pin, o_prog_rvalid, o_core_reset, o_sleeping;
  logic i_mclr_n_pin = 1'b1;
  logic i_brownout_pin = 1'b0;
  logic i_sleep_req = 1'b0;
  logic i_wdt_wake = 1'b0;
  logic i_irq_wake = 1'b0;
  prog_req_t i_prog_req;
  logic [CFG_W-1:0] o_prog_rdata;
  cfg_fields_t o_cfg;
  int err_total = 0;
  int tests_run = 0;
  int n;
  always #25 i_clk = ~i_clk;
  config_word_and_reset_hold #(.HOLD_CYCLES(HOLD)) dut (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_prog_mode_pin(i_prog_mode_pin),
    .i_prog_req(i_prog_req),
    .o_prog_rdata(o_prog_rdata),
    .o_prog_rvalid(o_prog_rvalid),
    .i_mclr_n_pin(i_mclr_n_pin),
    .i_brownout_pin(i_brownout_pin),
    .i_sleep_req(i_sleep_req),
    .i_wdt_wake(i_wdt_wake),
    .i_irq_wake(i_irq_wake),
    .o_core_reset(o_core_reset),
    .o_sleeping(o_sleeping),
    .o_cfg(o_cfg)
  );
  prog_model prog (.i_clk(i_clk), .o_prog_mode_pin(i_prog_mode_pin), .o_prog_req(i_prog_req),
    .i_prog_rdata(o_prog_rdata), .i_prog_rvalid(o_prog_rvalid));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("[ERR] %s exp %h got %h", nm, exp, got);
      err_total++;
    end
  endtask
  // bounded wait on the core reset level
  task automatic wait_rst(input logic lvl, output int cnt);
    cnt = 0;
    while (o_core_reset !== lvl)
    begin
      @(posedge i_clk);
      #1;
      cnt++;
      if (cnt > 200)
      begin
        $display("[ERR] core_reset exp %b got %b", lvl, o_core_reset);
        err_total++;
        end_of_test();
      end
    end
  endtask
  task automatic rd_chk(input logic [13:0] a, input logic ok, input logic [13:0] exp);
    prog.req(1'b0, 1'b1, 1'b0, a, 14'h0000);
    chk("rvalid", 16'(ok), 16'(prog.got_rd));
    if (ok)
      chk("rdata", 16'(exp), 16'(prog.last_rd));
  endtask
  // program one word and leave programming mode
  task automatic load(input logic [13:0] w);
    prog.mode(1'b1);
    prog.req(1'b0, 1'b0, 1'b1, CFG_ADDR, 14'h0000);
    prog.req(1'b1, 1'b0, 1'b0, CFG_ADDR, w);
    prog.mode(1'b0);
    wait_rst(1'b0, n);
  endtask
  task automatic t_pwrup();
    @(posedge i_clk);
    #1;
    chk("core_reset", 16'h0001, 16'(o_core_reset));
    chk("cfg blank", 16'h000b, 16'(o_cfg));
    wait_rst(1'b0, n);
    chk("pwrup len ok", 16'h0001, 16'(n >= HOLD && n <= HOLD + 2));
    $display("test pwrup done");
  endtask
  task automatic t_prog();
    rd_chk(CFG_ADDR, 1'b0, 14'h0000);
    prog.mode(1'b1);
    chk("prog holds", 16'h0001, 16'(o_core_reset));
    rd_chk(CFG_ADDR, 1'b1, 14'h3fff);
    rd_chk(14'h1fff, 1'b0, 14'h0000);
    rd_chk(14'h2001, 1'b1, 14'h3fff);
    prog.req(1'b1, 1'b0, 1'b0, CFG_ADDR, 14'h0000);
    rd_chk(CFG_ADDR, 1'b1, 14'h0086);
    prog.req(1'b0, 1'b0, 1'b1, 14'h2000, 14'h0000);
    rd_chk(CFG_ADDR, 1'b1, 14'h3fff);
    prog.mode(1'b0);
    load(14'h3aff);
    chk("cfg lower wp bor awake", 16'h002b, 16'(o_cfg));
    // brown-out code 10 must drop out while asleep
    @(posedge i_clk);
    i_sleep_req <= 1'b1;
    @(posedge i_clk);
    i_sleep_req <= 1'b0;
    #1;
    chk("cfg bor off asleep", 16'h0023, 16'(o_cfg));
    @(posedge i_clk);
    i_irq_wake <= 1'b1;
    @(posedge i_clk);
    i_irq_wake <= 1'b0;
    #1;
    chk("cfg bor on awake", 16'h002b, 16'(o_cfg));
    load(14'h0000);
    chk("cfg all programmed", 16'h01f4, 16'(o_cfg));
    $display("test prog done");
  endtask
  task automatic t_hold_cfg();
    chk("cfg kept", 16'h01f4, 16'(o_cfg));
    load(14'h3fff);
    chk("cfg erased word", 16'h000b, 16'(o_cfg));
    $display("test hold_cfg done");
  endtask
  task automatic t_sleep(input logic wdt_ok);
    @(posedge i_clk);
    i_sleep_req <= 1'b1;
    @(posedge i_clk);
    i_sleep_req <= 1'b0;
    #1;
    chk("sleeping", 16'h0001, 16'(o_sleeping));
    @(posedge i_clk);
    i_wdt_wake <= 1'b1;
    @(posedge i_clk);
    i_wdt_wake <= 1'b0;
    #1;
    chk("wdt wake", 16'(!wdt_ok), 16'(o_sleeping));
    @(posedge i_clk);
    i_irq_wake <= 1'b1;
    @(posedge i_clk);
    i_irq_wake <= 1'b0;
    #1;
    chk("irq wake", 16'h0000, 16'(o_sleeping));
    $display("test sleep done");
  endtask
  task automatic t_resets();
    @(posedge i_clk);
    i_mclr_n_pin <= 1'b0;
    wait_rst(1'b1, n);
    chk("mclr fast", 16'h0001, 16'(n <= 4));
    @(posedge i_clk);
    i_mclr_n_pin <= 1'b1;
    wait_rst(1'b0, n);
    // the long delay belongs to power-up and brown-out only, not to mclr
    chk("mclr no delay", 16'h0001, 16'(n <= 5));
    @(posedge i_clk);
    i_brownout_pin <= 1'b1;
    wait_rst(1'b1, n);
    chk("bor fast", 16'h0001, 16'(n <= 4));
    @(posedge i_clk);
    i_brownout_pin <= 1'b0;
    wait_rst(1'b0, n);
    chk("bor stretch", 16'h0001, 16'(n >= HOLD));
    $display("test resets done");
  endtask
  initial
  begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    t_pwrup();
    t_prog();
    t_sleep(1'b0);
    t_hold_cfg();
    t_sleep(1'b1);
    t_resets();
    end_of_test();
  end
endmodule
